/* logic/dacbf_pkg.sv */
// constants shared by the converter data buffer and flag logic
package dacbf_pkg;
    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_CTRL = 6'h01;
    localparam logic [5:0] IDX_EVCTRL = 6'h02;
    localparam logic [5:0] IDX_MASK_CLEAR = 6'h04;
    localparam logic [5:0] IDX_MASK_SET = 6'h05;
    localparam logic [5:0] IDX_FLAGS = 6'h06;
    localparam logic [5:0] IDX_STATUS = 6'h07;
    localparam logic [5:0] IDX_CONV = 6'h08;
    localparam logic [5:0] IDX_BUF = 6'h0C;

    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int CTRL_W = 3;
    localparam int CTRL_LEFT_JUSTIFY = 2;
    localparam int EV_W = 2;
    localparam int EV_IN_EN = 0;
    localparam int EV_OUT_EN = 1;
    localparam int FLAG_W = 3;
    localparam int FLAG_UNDERRUN = 0;
    localparam int FLAG_EMPTY = 1;
    localparam int FLAG_SYNC_READY = 2;
    localparam int STATUS_BUSY = 7;
    localparam int SAMPLE_W = 16;
    localparam int CODE_W = 10;
    localparam int LEFT_LSB = 6;

    // ------------------------------------------------------------
    // reset values, bus codes and timing
    // ------------------------------------------------------------
    localparam logic [15:0] SAMPLE_RESET = 16'h0000;
    localparam logic [2:0] FLAG_RESET = 3'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam int SYNC_CYCLES = 4;
    localparam int SYNC_CNT_W = 3;
endpackage

/* logic/dacbf_sync2.sv */
// two flip-flop synchroniser for a level from another clock domain
`timescale 1ns/100ps
module dacbf_sync2 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic stage1;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

/* logic/dacbf_wsync.sv */
// write synchroniser timer: busy while a register update crosses over
`timescale 1ns/100ps
module dacbf_wsync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // start pulse and progress
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam logic [dacbf_pkg::SYNC_CNT_W-1:0] LAST_CNT =
        dacbf_pkg::SYNC_CNT_W'(dacbf_pkg::SYNC_CYCLES - 1);
    logic [dacbf_pkg::SYNC_CNT_W-1:0] cnt;

    // a new start restarts the crossing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            cnt <= '0;
        end
        else if (start)
        begin
            busy <= 1'b1;
            cnt <= LAST_CNT;
        end
        else if (busy)
        begin
            if (cnt == '0)
                busy <= 1'b0;
            else
                cnt <= cnt - 1'b1;
        end
    end

    // completion in the last busy cycle
    assign done = busy && (cnt == '0) && !start;
endmodule

/* logic/dacbf_top.sv */
// converter data buffer, flags and interrupts behind an ahb-lite slave
`timescale 1ns/100ps
module dacbf_top (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic [1:0] HRESP,
    // events
    input wire logic START_EVT,
    output logic BUF_DRAINED_EVT,
    // converter side and interrupt
    output logic [9:0] CONV_CODE,
    output logic IRQ
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic dph_valid;
    logic dph_write;
    logic [dacbf_pkg::IDX_W-1:0] dph_idx;
    logic [dacbf_pkg::CTRL_W-1:0] secondary_control;
    logic [dacbf_pkg::EV_W-1:0] event_control;
    logic [dacbf_pkg::FLAG_W-1:0] irq_enable;
    logic [dacbf_pkg::FLAG_W-1:0] dac_irq_flags;
    logic flag_underrun;
    logic flag_empty;
    logic flag_sync_ready;
    logic [dacbf_pkg::SAMPLE_W-1:0] conversion_value;
    logic [dacbf_pkg::SAMPLE_W-1:0] buffered_sample;
    logic buf_full;
    logic evt_sync;
    logic evt_prev;
    logic evt_pulse;
    logic wr_any;
    logic wr_conv;
    logic wr_buf;
    logic wr_flags;
    logic xfer;
    logic underrun;
    logic sync_start;
    logic sync_in_progress;
    logic sync_done;
    logic left_justify;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ------------------------------------------------------------
    assign HREADYOUT = 1'b1;
    assign HRESP = dacbf_pkg::RESP_OKAY;

    // address phase capture
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            dph_valid <= 1'b0;
            dph_write <= 1'b0;
            dph_idx <= '0;
        end
        else if (HREADY)
        begin
            dph_valid <= HSEL && HTRANS[1];
            dph_write <= HWRITE;
            dph_idx <= HADDR[dacbf_pkg::IDX_W+1:2];
        end
    end

    // data phase write strobes
    assign wr_any = dph_valid && dph_write;
    assign wr_conv = wr_any && (dph_idx == dacbf_pkg::IDX_CONV);
    assign wr_buf = wr_any && (dph_idx == dacbf_pkg::IDX_BUF);
    assign wr_flags = wr_any && (dph_idx == dacbf_pkg::IDX_FLAGS);

    // read mux; sample registers and unmapped words read zero
    always_comb
    begin
        next_rdata = dacbf_pkg::WORD_ZERO;
        case (HADDR[dacbf_pkg::IDX_W+1:2])
            dacbf_pkg::IDX_CTRL: next_rdata[dacbf_pkg::CTRL_W-1:0] = secondary_control;
            dacbf_pkg::IDX_EVCTRL: next_rdata[dacbf_pkg::EV_W-1:0] = event_control;
            dacbf_pkg::IDX_MASK_CLEAR: next_rdata[dacbf_pkg::FLAG_W-1:0] = irq_enable;
            dacbf_pkg::IDX_MASK_SET: next_rdata[dacbf_pkg::FLAG_W-1:0] = irq_enable;
            dacbf_pkg::IDX_FLAGS: next_rdata[dacbf_pkg::FLAG_W-1:0] = dac_irq_flags;
            dacbf_pkg::IDX_STATUS: next_rdata[dacbf_pkg::STATUS_BUSY] = sync_in_progress;
            default: next_rdata = dacbf_pkg::WORD_ZERO;
        endcase
    end

    // read data registered for the data phase
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            HRDATA <= dacbf_pkg::WORD_ZERO;
        else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
            HRDATA <= next_rdata;
    end

    // ------------------------------------------------------------
    // control, event control and interrupt enables
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            secondary_control <= '0;
            event_control <= '0;
        end
        else if (wr_any && dph_idx == dacbf_pkg::IDX_CTRL)
            secondary_control <= HWDATA[dacbf_pkg::CTRL_W-1:0];
        else if (wr_any && dph_idx == dacbf_pkg::IDX_EVCTRL)
            event_control <= HWDATA[dacbf_pkg::EV_W-1:0];
    end

    assign left_justify = secondary_control[dacbf_pkg::CTRL_LEFT_JUSTIFY];

    // ones set or clear enables, zeros leave them
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            irq_enable <= dacbf_pkg::FLAG_RESET;
        else if (wr_any && dph_idx == dacbf_pkg::IDX_MASK_SET)
            irq_enable <= irq_enable | HWDATA[dacbf_pkg::FLAG_W-1:0];
        else if (wr_any && dph_idx == dacbf_pkg::IDX_MASK_CLEAR)
            irq_enable <= irq_enable & ~HWDATA[dacbf_pkg::FLAG_W-1:0];
    end

    // ------------------------------------------------------------
    // start event input and buffer transfer
    // ------------------------------------------------------------
    dacbf_sync2 u_evt_sync (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .din(START_EVT),
        .dout(evt_sync)
    );

    // rising edge of the synchronised event
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            evt_prev <= 1'b0;
        else
            evt_prev <= evt_sync;
    end

    assign evt_pulse = evt_sync && !evt_prev && event_control[dacbf_pkg::EV_IN_EN];
    assign xfer = evt_pulse && buf_full;
    assign underrun = evt_pulse && !buf_full;

    // buffered sample keeps the latest write
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            buffered_sample <= dacbf_pkg::SAMPLE_RESET;
        else if (wr_buf)
            buffered_sample <= HWDATA[dacbf_pkg::SAMPLE_W-1:0];
    end

    // new data marker; a write in the transfer cycle refills it
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            buf_full <= 1'b0;
        else if (wr_buf)
            buf_full <= 1'b1;
        else if (xfer)
            buf_full <= 1'b0;
    end

    // conversion data: software write wins over a transfer
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            conversion_value <= dacbf_pkg::SAMPLE_RESET;
        else if (wr_conv)
            conversion_value <= HWDATA[dacbf_pkg::SAMPLE_W-1:0];
        else if (xfer)
            conversion_value <= buffered_sample;
    end

    // drained event pulse
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            BUF_DRAINED_EVT <= 1'b0;
        else
            BUF_DRAINED_EVT <= xfer && event_control[dacbf_pkg::EV_OUT_EN];
    end

    // ------------------------------------------------------------
    // converter-side update after the crossing
    // ------------------------------------------------------------
    assign sync_start = wr_conv || wr_buf || xfer;

    dacbf_wsync u_wsync (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .start(sync_start),
        .busy(sync_in_progress),
        .done(sync_done)
    );

    // selected ten bits of the conversion data
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            CONV_CODE <= '0;
        else if (sync_done && left_justify)
            CONV_CODE <= conversion_value[dacbf_pkg::SAMPLE_W-1:dacbf_pkg::LEFT_LSB];
        else if (sync_done)
            CONV_CODE <= conversion_value[dacbf_pkg::CODE_W-1:0];
    end

    // ------------------------------------------------------------
    // sticky flags: hardware set wins over a written one
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            flag_underrun <= 1'b0;
        else if (underrun)
            flag_underrun <= 1'b1;
        else if (wr_flags && HWDATA[dacbf_pkg::FLAG_UNDERRUN])
            flag_underrun <= 1'b0;
    end

    // buffer-empty set only by a real transfer
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            flag_empty <= 1'b0;
        else if (xfer)
            flag_empty <= 1'b1;
        else if (wr_buf || (wr_flags && HWDATA[dacbf_pkg::FLAG_EMPTY]))
            flag_empty <= 1'b0;
    end

    // sync-ready set when a crossing completes
    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            flag_sync_ready <= 1'b0;
        else if (sync_done)
            flag_sync_ready <= 1'b1;
        else if (wr_flags && HWDATA[dacbf_pkg::FLAG_SYNC_READY])
            flag_sync_ready <= 1'b0;
    end

    // flag bits gathered into the register view, one driver per bit
    always_comb
    begin
        dac_irq_flags = dacbf_pkg::FLAG_RESET;
        dac_irq_flags[dacbf_pkg::FLAG_UNDERRUN] = flag_underrun;
        dac_irq_flags[dacbf_pkg::FLAG_EMPTY] = flag_empty;
        dac_irq_flags[dacbf_pkg::FLAG_SYNC_READY] = flag_sync_ready;
    end

    // level interrupt from enabled flags
    assign IRQ = |(dac_irq_flags & irq_enable);

    // ------------------------------------------------------------
    // assertions and cover points
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);

    a_empty_on_xfer: assert property (xfer |=> dac_irq_flags[1])
        else $error("buffer-empty not set after transfer");
    a_empty_on_write: assert property (wr_buf && !xfer |=> !dac_irq_flags[1])
        else $error("buffer-empty not cleared by buffer write");
    a_irq_empty: assert property (dac_irq_flags[1] && irq_enable[1] |-> IRQ)
        else $error("buffer-empty interrupt missing");
    a_underrun_set: assert property (underrun |=> dac_irq_flags[0])
        else $error("underrun flag not set");
    a_underrun_sticky: assert property (dac_irq_flags[0] && !(wr_flags && HWDATA[0])
        |=> dac_irq_flags[0])
        else $error("underrun flag lost without a written one");
    a_irq_underrun: assert property (dac_irq_flags[0] && irq_enable[0] |-> IRQ)
        else $error("underrun interrupt missing");
    a_sync_ready_flag_clear: assert property (wr_flags && HWDATA[2] && !sync_done
        |=> !dac_irq_flags[2])
        else $error("sync-ready not cleared");
    a_busy_start: assert property (sync_start |=> sync_in_progress)
        else $error("sync busy not set");
    a_busy_end: assert property (sync_start ##1 (!sync_start) [*4] |=> !sync_in_progress)
        else $error("sync busy not cleared after crossing");
    a_code_select: assert property (sync_done && !left_justify
        |=> CONV_CODE == $past(conversion_value[9:0]))
        else $error("right-justified code wrong");
    a_buf_hold: assert property (wr_buf |=> buffered_sample == $past(HWDATA[15:0]))
        else $error("buffered sample not stored");
    a_sample_unread: assert property (HREADY && HSEL && HTRANS[1] && !HWRITE
        && HADDR[7:2] == dacbf_pkg::IDX_BUF |=> HRDATA == 32'h0000_0000)
        else $error("buffered sample readable");
    a_evt_disabled: assert property (!event_control[0] |-> !xfer && !underrun)
        else $error("event acted while disabled");
    a_drain_evt: assert property (xfer && event_control[1] |=> BUF_DRAINED_EVT)
        else $error("drained event missing");
    a_mask_set: assert property (wr_any && dph_idx == dacbf_pkg::IDX_MASK_SET && HWDATA[1]
        |=> irq_enable[1])
        else $error("mask set ignored");
    a_underrun_keep: assert property (underrun && !wr_conv
        |=> $stable(conversion_value) && !$rose(dac_irq_flags[1]))
        else $error("underrun changed conversion data");
    a_code_left: assert property (sync_done && left_justify
        |=> CONV_CODE == $past(conversion_value[15:6]))
        else $error("left-justified code wrong");
    a_drain_quiet: assert property (!xfer |=> !BUF_DRAINED_EVT)
        else $error("drained event without a transfer");
    a_conv_load: assert property (xfer && !wr_conv |=> conversion_value == $past(buffered_sample))
        else $error("transfer did not load conversion data");

    c_transfer: cover property (xfer ##1 BUF_DRAINED_EVT);
    c_underrun: cover property (underrun ##1 IRQ);
    c_sync_done: cover property (sync_start ##[1:8] sync_done);
    c_left_code: cover property (sync_done && left_justify);
endmodule

/* verification/dacbf_top_tb.sv */
// self-checking bench for the converter data buffer, flags and interrupt block
`timescale 1ns/100ps
module dacbf_top_tb;
    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    logic REF_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0000_0000;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0000_0000;
    logic HREADY;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic [1:0] HRESP;
    logic START_EVT = 1'b0;
    logic BUF_DRAINED_EVT;
    logic [9:0] CONV_CODE;
    logic IRQ;
    int fails = 0;
    int total_checks = 0;
    int drains = 0;
    int d;
    logic [31:0] rd;
    logic [15:0] smp;
    logic lj;
    logic [9:0] code;
    logic [5:0] regs [8] = '{dacbf_pkg::IDX_CTRL, dacbf_pkg::IDX_EVCTRL,
        dacbf_pkg::IDX_MASK_CLEAR, dacbf_pkg::IDX_MASK_SET, dacbf_pkg::IDX_FLAGS,
        dacbf_pkg::IDX_STATUS, dacbf_pkg::IDX_CONV, dacbf_pkg::IDX_BUF};

    // single slave, so its ready is the bus ready
    assign HREADY = HREADYOUT;

    // 100 MHz clock
    always #5 REF_CLK = ~REF_CLK;

    // count drained-event pulses
    always @(posedge REF_CLK)
        if (BUF_DRAINED_EVT === 1'b1)
            drains <= drains + 1;

    dacbf_top u_dut (
        .REF_CLK(REF_CLK),
        .RESET_N(RESET_N),
        .HSEL(HSEL),
        .HADDR(HADDR),
        .HTRANS(HTRANS),
        .HWRITE(HWRITE),
        .HSIZE(HSIZE),
        .HWDATA(HWDATA),
        .HREADY(HREADY),
        .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT),
        .HRESP(HRESP),
        .START_EVT(START_EVT),
        .BUF_DRAINED_EVT(BUF_DRAINED_EVT),
        .CONV_CODE(CONV_CODE),
        .IRQ(IRQ)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // expected converter code from a sample and the justification
    function automatic logic [9:0] code_of(input logic [15:0] s, input logic l);
        return l ? s[15:6] : s[9:0];
    endfunction

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one ahb-lite single transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] dat);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h00_0000, i, 2'b00};
        do @(posedge REF_CLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= dat;
        do @(posedge REF_CLK); while (HREADY !== 1'b1);
        rd = HRDATA;
        chk({30'h0, HRESP}, {30'h0, dacbf_pkg::RESP_OKAY});
        chk({31'h0, HREADYOUT}, 32'h0000_0001);
    endtask

    // read flags and compare the masked bits
    task automatic chkf(input logic [2:0] m, input logic [2:0] e);
        bus(1'b0, dacbf_pkg::IDX_FLAGS, 32'h0000_0000);
        chk({29'h0, rd[2:0] & m}, {29'h0, e & m});
    endtask

    // one start event, held past the synchroniser, then let it settle
    task automatic fire();
        START_EVT <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        START_EVT <= 1'b0;
        repeat (8) @(posedge REF_CLK);
    endtask

    // verdict and end of run
    task automatic end_of_test();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog against a hang
    initial
    begin
        repeat (6000) @(posedge REF_CLK);
        fails++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h73e845b9));
        repeat (20) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        @(posedge REF_CLK);
        chk({22'h0, CONV_CODE}, 32'h0000_0000);
        chk({31'h0, IRQ}, 32'h0000_0000);
        // every register reads zero after reset; sample registers always read zero
        foreach (regs[k])
        begin
            bus(1'b0, regs[k], 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        // unmapped place ignores writes and reads zero
        bus(1'b1, 6'h3F, $urandom);
        bus(1'b0, 6'h3F, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // random samples through the buffer, both justifications
        bus(1'b1, dacbf_pkg::IDX_EVCTRL, 32'h0000_0003);
        for (int n = 0; n < 8; n++)
        begin
            smp = (n == 0) ? 16'hFFC0 : 16'($urandom);
            lj = n[0];
            bus(1'b1, dacbf_pkg::IDX_CTRL, {29'h0, lj, 2'b00});
            bus(1'b1, dacbf_pkg::IDX_BUF, $urandom);
            bus(1'b1, dacbf_pkg::IDX_BUF, {16'($urandom), smp});
            chkf(3'b011, 3'b000);
            bus(1'b0, dacbf_pkg::IDX_BUF, 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            d = drains;
            fire();
            chkf(3'b011, 3'b010);
            chk(drains, d + 1);
            chk({22'h0, CONV_CODE}, {22'h0, code_of(smp, lj)});
        end
        // underrun on an empty buffer keeps the converter code
        code = code_of(smp, lj);
        bus(1'b1, dacbf_pkg::IDX_FLAGS, 32'h0000_0002);
        chkf(3'b011, 3'b000);
        d = drains;
        fire();
        chkf(3'b011, 3'b001);
        chk({22'h0, CONV_CODE}, {22'h0, code});
        chk(drains, d);
        // zeros written to the flags change nothing
        bus(1'b1, dacbf_pkg::IDX_FLAGS, 32'h0000_0000);
        chkf(3'b001, 3'b001);
        // underrun interrupt through mask set and clear
        bus(1'b1, dacbf_pkg::IDX_MASK_SET, 32'h0000_0001);
        bus(1'b0, dacbf_pkg::IDX_MASK_CLEAR, 32'h0000_0000);
        chk({29'h0, rd[2:0]}, 32'h0000_0001);
        chk({31'h0, IRQ}, 32'h0000_0001);
        bus(1'b1, dacbf_pkg::IDX_FLAGS, 32'h0000_0001);
        chkf(3'b001, 3'b000);
        chk({31'h0, IRQ}, 32'h0000_0000);
        bus(1'b1, dacbf_pkg::IDX_MASK_CLEAR, 32'h0000_0001);
        bus(1'b0, dacbf_pkg::IDX_MASK_SET, 32'h0000_0000);
        chk({29'h0, rd[2:0]}, 32'h0000_0000);
        // buffer-empty interrupt
        bus(1'b1, dacbf_pkg::IDX_MASK_SET, 32'h0000_0002);
        bus(1'b1, dacbf_pkg::IDX_BUF, {16'h0000, smp});
        chk({31'h0, IRQ}, 32'h0000_0000);
        fire();
        chkf(3'b010, 3'b010);
        chk({31'h0, IRQ}, 32'h0000_0001);
        bus(1'b1, dacbf_pkg::IDX_FLAGS, 32'h0000_0002);
        bus(1'b0, dacbf_pkg::IDX_STATUS, 32'h0000_0000);
        chk({31'h0, IRQ}, 32'h0000_0000);
        bus(1'b1, dacbf_pkg::IDX_MASK_CLEAR, 32'h0000_0002);
        // sync-ready flag clears on a written one
        chkf(3'b100, 3'b100);
        bus(1'b1, dacbf_pkg::IDX_FLAGS, 32'h0000_0004);
        chkf(3'b100, 3'b000);
        // direct conversion write: busy while crossing, then code lands
        smp = 16'($urandom);
        bus(1'b1, dacbf_pkg::IDX_CONV, {16'h0000, smp});
        bus(1'b0, dacbf_pkg::IDX_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0080);
        repeat (8) @(posedge REF_CLK);
        bus(1'b0, dacbf_pkg::IDX_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({22'h0, CONV_CODE}, {22'h0, code_of(smp, lj)});
        // events ignored while the event input is disabled
        code = code_of(smp, lj);
        smp = 16'($urandom);
        bus(1'b1, dacbf_pkg::IDX_EVCTRL, 32'h0000_0002);
        bus(1'b1, dacbf_pkg::IDX_BUF, {16'h0000, smp});
        repeat (8) @(posedge REF_CLK);
        bus(1'b1, dacbf_pkg::IDX_FLAGS, 32'h0000_0007);
        d = drains;
        fire();
        chkf(3'b011, 3'b000);
        chk(drains, d);
        chk({22'h0, CONV_CODE}, {22'h0, code});
        // transfer with the drained event output disabled
        bus(1'b1, dacbf_pkg::IDX_EVCTRL, 32'h0000_0001);
        fire();
        chk(drains, d);
        chk({22'h0, CONV_CODE}, {22'h0, code_of(smp, lj)});
        // reset in mid-run clears enables, flags and the converter code
        bus(1'b1, dacbf_pkg::IDX_MASK_SET, 32'h0000_0007);
        RESET_N <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        @(posedge REF_CLK);
        chk({22'h0, CONV_CODE}, 32'h0000_0000);
        chk({31'h0, IRQ}, 32'h0000_0000);
        chkf(3'b111, 3'b000);
        bus(1'b0, dacbf_pkg::IDX_MASK_SET, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        end_of_test();
    end
endmodule
